// *** hw/dca_apb.sv ***
// apb slave handshake: one wait-free access phase, registered answer
`timescale 1ns/10ps
module dca_apb (
  input wire logic core_clk,
  input wire logic rst,
  input wire dca_pkg::dca_apb_req_t req,
  input wire logic hit,
  input wire logic [dca_pkg::DW-1:0] rd_data,
  output dca_pkg::dca_apb_rsp_t rsp,
  output logic wr_commit
);
  wire setup = req.psel && !req.penable && !rsp.pready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else if (setup) begin
      rsp.pready <= 1'b1;
      rsp.pslverr <= !hit;
      rsp.prdata <= (hit && !req.pwrite) ? rd_data : '0;
    end else begin
      rsp <= '0;
    end
  end

  // writes land only at the edge where pready is seen high
  assign wr_commit = req.psel && req.penable && req.pwrite &&
    rsp.pready && !rsp.pslverr;
endmodule

// *** hw/dca_pick.sv ***
// priority pick among queued channels: highest enabled level, lowest index
`timescale 1ns/10ps
module dca_pick (
  input wire logic [dca_pkg::NCH-1:0] queued,
  input wire logic [dca_pkg::NCH*dca_pkg::LVLW-1:0] lvl,
  input wire logic [dca_pkg::NLVL-1:0] lvl_en,
  output logic found,
  output logic [dca_pkg::CHW-1:0] idx
);
  // returns {found, index} of the lowest set bit
  function automatic logic [dca_pkg::CHW:0] lowest_set(
    input logic [dca_pkg::NCH-1:0] m);
    logic [dca_pkg::CHW:0] r;
    r = '0;
    for (int i = dca_pkg::NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, i[dca_pkg::CHW-1:0]};
      end
    end
    return r;
  endfunction

  logic [dca_pkg::CHW:0] lvl_hit [dca_pkg::NLVL];

  for (genvar l = 0; l < dca_pkg::NLVL; l++) begin : g_lvl
    logic [dca_pkg::NCH-1:0] in_lvl;
    for (genvar c = 0; c < dca_pkg::NCH; c++) begin : g_ch
      assign in_lvl[c] = queued[c] && lvl_en[l] &&
        (lvl[c*dca_pkg::LVLW +: dca_pkg::LVLW] == dca_pkg::LVLW'(l));
    end
    assign lvl_hit[l] = lowest_set(in_lvl);
  end

  // higher level number wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int l = 0; l < dca_pkg::NLVL; l++) begin
      if (lvl_hit[l][dca_pkg::CHW]) begin
        found = 1'b1;
        idx = lvl_hit[l][dca_pkg::CHW-1:0];
      end
    end
  end
endmodule

// *** hw/dca_top.sv ***
// dma channel arbiter: pending/busy bookkeeping, grant and apb registers
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - arbiter picks one active channel from the queued pending ones
// - granting a channel clears its pending flag
// - first burst of a request sets busy, kept through later bursts
// - after bursts: requeue, wait for trigger, suspend or disable
// - a requeued channel keeps its busy flag set
// - waiting, suspended or disabled channel gets busy cleared
// - suspending removes from queue but pending flag stays
// - resuming puts the channel back into the queue
// - disabling a pending channel removes it and clears pending
// - each channel has one of four priority levels
// - higher enabled level number wins arbitration
module dca_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire dca_pkg::dca_apb_req_t apb_req,
  output dca_pkg::dca_apb_rsp_t apb_rsp,
  input wire logic [dca_pkg::NCH-1:0] chan_trig,
  input wire dca_pkg::dca_done_t burst_done,
  output dca_pkg::dca_grant_t grant,
  output logic irq
);
  localparam int NCH = dca_pkg::NCH;
  localparam int CHW = dca_pkg::CHW;

  dca_pkg::dca_state_t state_reg;
  dca_pkg::dca_grant_t grant_reg;
  logic [CHW-1:0] active_ch_reg;
  logic [dca_pkg::NLVL-1:0] lvl_en_reg;
  logic [NCH*dca_pkg::LVLW-1:0] lvl_reg;
  logic [NCH-1:0] chen_reg;
  logic [NCH-1:0] chen_next;
  logic [NCH-1:0] susp_reg;
  logic [NCH-1:0] susp_next;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] pend_next;
  logic [NCH-1:0] busy_reg;
  logic [NCH-1:0] busy_next;
  logic [NCH-1:0] flag_reg;
  logic [NCH-1:0] flag_next;
  logic [NCH-1:0] mask_reg;
  logic irq_reg;
  logic wr_commit;
  logic pick_found;
  logic [CHW-1:0] pick_idx;

  // address decode
  wire [dca_pkg::AW-1:0] addr = apb_req.paddr;
  wire [NCH-1:0] wdata = apb_req.pwdata[NCH-1:0];
  wire sel_ctrl = addr == dca_pkg::OFS_CTRL;
  wire sel_chen = addr == dca_pkg::OFS_CHEN;
  wire sel_susp = addr == dca_pkg::OFS_SUSP;
  wire sel_resume = addr == dca_pkg::OFS_RESUME;
  wire sel_lvl = addr == dca_pkg::OFS_LVL;
  wire sel_pend = addr == dca_pkg::OFS_PEND;
  wire sel_busy = addr == dca_pkg::OFS_BUSY;
  wire sel_flag = addr == dca_pkg::OFS_FLAG;
  wire sel_mask = addr == dca_pkg::OFS_MASK;
  wire sel_swtrig = addr == dca_pkg::OFS_SWTRIG;
  wire sel_active = addr == dca_pkg::OFS_ACTIVE;
  wire addr_hit = sel_ctrl || sel_chen || sel_susp || sel_resume ||
    sel_lvl || sel_pend || sel_busy || sel_flag || sel_mask ||
    sel_swtrig || sel_active;

  wire wr_ctrl = wr_commit && sel_ctrl;
  wire wr_chen = wr_commit && sel_chen;
  wire wr_susp = wr_commit && sel_susp;
  wire wr_resume = wr_commit && sel_resume;
  wire wr_lvl = wr_commit && sel_lvl;
  wire wr_flag = wr_commit && sel_flag;
  wire wr_mask = wr_commit && sel_mask;
  wire wr_swtrig = wr_commit && sel_swtrig;

  // read mux; write-only trigger register reads zero
  wire [dca_pkg::DW-1:0] rd_data =
    sel_ctrl ? {28'h0000000, lvl_en_reg} :
    sel_chen ? {24'h000000, chen_reg} :
    (sel_susp || sel_resume) ? {24'h000000, susp_reg} :
    sel_lvl ? {16'h0000, lvl_reg} :
    sel_pend ? {24'h000000, pend_reg} :
    sel_busy ? {24'h000000, busy_reg} :
    sel_flag ? {24'h000000, flag_reg} :
    sel_mask ? {24'h000000, mask_reg} :
    sel_active ? {24'h000000, 1'b0, (state_reg != dca_pkg::DCA_ST_IDLE),
      state_reg, 1'b0, active_ch_reg} :
    32'h00000000;

  dca_apb u_apb (
    .core_clk(core_clk),
    .rst(rst),
    .req(apb_req),
    .hit(addr_hit),
    .rd_data(rd_data),
    .rsp(apb_rsp),
    .wr_commit(wr_commit)
  );

  // channels that are pending, enabled and not suspended stand in the queue
  wire [NCH-1:0] queued = pend_reg & chen_reg & ~susp_reg;

  dca_pick u_pick (
    .queued(queued),
    .lvl(lvl_reg),
    .lvl_en(lvl_en_reg),
    .found(pick_found),
    .idx(pick_idx)
  );

  wire st_idle = state_reg == dca_pkg::DCA_ST_IDLE;
  wire st_run = state_reg == dca_pkg::DCA_ST_RUN;
  wire do_grant = st_idle && pick_found;
  wire do_done = st_run && burst_done.valid;
  wire [NCH-1:0] trig_all = chan_trig | (wr_swtrig ? wdata : '0);
  wire [NCH-1:0] grant_vec = do_grant ? (NCH'(1) << pick_idx) : '0;
  wire [NCH-1:0] done_vec = do_done ? (NCH'(1) << active_ch_reg) : '0;
  wire out_requeue = burst_done.outcome == dca_pkg::DCA_OUT_REQUEUE;
  wire out_susp = burst_done.outcome == dca_pkg::DCA_OUT_SUSPEND;
  wire out_dis = burst_done.outcome == dca_pkg::DCA_OUT_DISABLE;

  // per-channel bookkeeping; pending and flag sets follow their clears, busy is set before it is cleared, and the channel-enable mask on pending is applied last
  always_comb begin
    chen_next = wr_chen ? wdata : chen_reg;
    susp_next = susp_reg;
    if (wr_susp) begin
      susp_next = susp_next | wdata;
    end
    if (wr_resume) begin
      susp_next = susp_next & ~wdata;
    end
    pend_next = pend_reg & ~grant_vec;
    busy_next = busy_reg | grant_vec;
    flag_next = wr_flag ? (flag_reg & ~wdata) : flag_reg;
    if (do_done) begin
      unique case (burst_done.outcome)
        dca_pkg::DCA_OUT_REQUEUE: begin
          pend_next = pend_next | done_vec;
        end
        dca_pkg::DCA_OUT_WAIT: begin
          busy_next = busy_next & ~done_vec;
        end
        dca_pkg::DCA_OUT_SUSPEND: begin
          busy_next = busy_next & ~done_vec;
          susp_next = susp_next | done_vec;
        end
        dca_pkg::DCA_OUT_DISABLE: begin
          busy_next = busy_next & ~done_vec;
          chen_next = chen_next & ~done_vec;
        end
      endcase
      if (!out_requeue) begin
        flag_next = flag_next | done_vec;
      end
    end
    pend_next = pend_next | (trig_all & chen_reg & ~susp_reg);
    pend_next = pend_next & chen_next;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chen_reg <= dca_pkg::CHEN_RST;
      susp_reg <= '0;
      pend_reg <= '0;
      busy_reg <= '0;
      flag_reg <= '0;
    end else begin
      chen_reg <= chen_next;
      susp_reg <= susp_next;
      pend_reg <= pend_next;
      busy_reg <= busy_next;
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lvl_en_reg <= dca_pkg::LVLEN_RST;
      lvl_reg <= dca_pkg::LVL_RST;
      mask_reg <= dca_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        lvl_en_reg <= apb_req.pwdata[dca_pkg::NLVL-1:0];
      end
      if (wr_lvl) begin
        lvl_reg <= apb_req.pwdata[NCH*dca_pkg::LVLW-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wdata;
      end
    end
  end

  // grant sequencer; the engine runs one channel's bursts at a time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= dca_pkg::DCA_ST_IDLE;
      grant_reg <= '0;
      active_ch_reg <= '0;
    end else begin
      grant_reg.valid <= 1'b0;
      unique case (state_reg)
        dca_pkg::DCA_ST_IDLE: begin
          if (do_grant) begin
            state_reg <= dca_pkg::DCA_ST_GRANT;
            grant_reg.valid <= 1'b1;
            grant_reg.first <= !busy_reg[pick_idx];
            grant_reg.ch <= pick_idx;
            active_ch_reg <= pick_idx;
          end
        end
        dca_pkg::DCA_ST_GRANT: begin
          state_reg <= dca_pkg::DCA_ST_RUN;
        end
        dca_pkg::DCA_ST_RUN: begin
          if (burst_done.valid) begin
            state_reg <= dca_pkg::DCA_ST_IDLE;
          end
        end
        default: begin
          state_reg <= dca_pkg::DCA_ST_IDLE;
        end
      endcase
    end
  end

  // level interrupt, registered so the pin has no decode glitches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_next & mask_reg);
    end
  end

  assign grant = grant_reg;
  assign irq = irq_reg;

  // checks
  wire [NCH-1:0] hold_vec = pend_reg & susp_reg & chen_reg;
  wire [NCH-1:0] resumed_vec = hold_vec & wdata;
  wire [dca_pkg::LVLW-1:0] pick_lvl =
    lvl_reg[pick_idx*dca_pkg::LVLW +: dca_pkg::LVLW];

  sequence s_grant_pulse;
    grant_reg.valid ##1 (!grant_reg.valid && state_reg ==
      dca_pkg::DCA_ST_RUN);
  endsequence

  a_grant_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    do_grant |=> s_grant_pulse)
    else $error("grant did not pulse for one cycle");

  a_grant_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    (do_grant && !trig_all[pick_idx]) |=> !pend_reg[$past(pick_idx)])
    else $error("granted channel still pending");

  // busy is judged at the pick edge, not against the previous grant's channel
  a_first_busy: assert property (
    @(posedge core_clk) disable iff (rst)
    do_grant |=> busy_reg[grant_reg.ch] && grant_reg.ch == $past(pick_idx) &&
      (grant_reg.first == !$past(busy_reg[pick_idx])))
    else $error("busy or first wrong at grant");

  a_requeue_busy: assert property (
    @(posedge core_clk) disable iff (rst)
    (do_done && out_requeue && !wr_chen) |=>
      busy_reg[$past(active_ch_reg)] && pend_reg[$past(active_ch_reg)])
    else $error("requeued channel lost busy or pending");

  a_end_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    (do_done && !out_requeue) |=> !busy_reg[$past(active_ch_reg)] &&
      flag_reg[$past(active_ch_reg)] && st_idle)
    else $error("finished channel still busy");

  a_done_effect: assert property (
    @(posedge core_clk) disable iff (rst)
    (do_done && (out_susp || out_dis)) |=>
      (susp_reg[$past(active_ch_reg)] || !chen_reg[$past(active_ch_reg)]))
    else $error("suspend or disable outcome not applied");

  a_susp_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    (!wr_chen && !(do_done && out_dis)) |=>
      ($past(hold_vec) & ~pend_reg) == '0)
    else $error("suspended channel lost pending");

  a_resume_queue: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_resume && !wr_chen && !(do_done && out_dis) && resumed_vec != '0)
      |=> queued != '0)
    else $error("resumed channel not queued");

  a_disable_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_chen |=> (pend_reg & ~chen_reg) == '0)
    else $error("disabled channel still pending");

  a_level_win: assert property (
    @(posedge core_clk) disable iff (rst)
    pick_found |-> lvl_en_reg[pick_lvl] && queued[pick_idx])
    else $error("pick from disabled level or not queued");

  a_trig_sets: assert property (
    @(posedge core_clk) disable iff (rst)
    (chan_trig[0] && chen_reg[0] && !susp_reg[0] && !wr_chen &&
      !(do_done && out_dis)) |=> pend_reg[0])
    else $error("trigger did not set pending");

  a_irq_level: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 irq == $past(|(flag_next & mask_reg)))
    else $error("interrupt does not follow flags");
endmodule

// *** inc/dca_pkg.sv ***
// shared constants, types and carriers of the dma channel arbiter
package dca_pkg;
  localparam int NCH = 8;
  localparam int CHW = 3;
  localparam int NLVL = 4;
  localparam int LVLW = 2;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam logic [AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [AW-1:0] OFS_CHEN = 12'h004;
  localparam logic [AW-1:0] OFS_SUSP = 12'h008;
  localparam logic [AW-1:0] OFS_RESUME = 12'h00c;
  localparam logic [AW-1:0] OFS_LVL = 12'h010;
  localparam logic [AW-1:0] OFS_PEND = 12'h014;
  localparam logic [AW-1:0] OFS_BUSY = 12'h018;
  localparam logic [AW-1:0] OFS_FLAG = 12'h01c;
  localparam logic [AW-1:0] OFS_MASK = 12'h020;
  localparam logic [AW-1:0] OFS_SWTRIG = 12'h024;
  localparam logic [AW-1:0] OFS_ACTIVE = 12'h028;
  localparam logic [NLVL-1:0] LVLEN_RST = 4'hf;
  localparam logic [NCH-1:0] CHEN_RST = 8'h00;
  localparam logic [NCH-1:0] MASK_RST = 8'h00;
  localparam logic [NCH*LVLW-1:0] LVL_RST = 16'h0000;
  typedef enum logic [1:0] {
    DCA_OUT_REQUEUE = 2'h0,
    DCA_OUT_WAIT = 2'h1,
    DCA_OUT_SUSPEND = 2'h2,
    DCA_OUT_DISABLE = 2'h3
  } dca_outcome_t;
  typedef enum logic [1:0] {
    DCA_ST_IDLE = 2'b00,
    DCA_ST_GRANT = 2'b01,
    DCA_ST_RUN = 2'b11
  } dca_state_t;
  typedef struct packed {
    logic valid;
    logic first;
    logic [CHW-1:0] ch;
  } dca_grant_t;
  typedef struct packed {
    logic valid;
    dca_outcome_t outcome;
  } dca_done_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } dca_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DW-1:0] prdata;
  } dca_apb_rsp_t;
endpackage

// *** tb/dca_channel_arbiter_test.sv ***
// self-checking bench of the channel arbiter with a cycle model
`timescale 1ns/10ps
module dca_channel_arbiter_test;
  logic core_clk;
  logic rst;
  dca_pkg::dca_apb_req_t apb_req;
  dca_pkg::dca_apb_rsp_t apb_rsp;
  logic [7:0] chan_trig;
  dca_pkg::dca_done_t burst_done;
  dca_pkg::dca_grant_t grant;
  logic irq;
  logic [3:0] delay;
  dca_pkg::dca_outcome_t outcome;
  int miscompares = 0;
  int num_checks = 0;
  bit [7:0] pend, busy, susp, chen, flag, mask;
  bit [15:0] lvl;
  bit [3:0] lvlen;
  bit gv, gf, m_irq;
  int st, cur;

  dca_top dca_top_i (.core_clk(core_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .chan_trig(chan_trig), .burst_done(burst_done),
    .grant(grant), .irq(irq));
  dca_engine_model dca_engine_model_i (.core_clk(core_clk), .rst(rst),
    .grant(grant), .delay(delay), .outcome(outcome),
    .burst_done(burst_done));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string nm);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic bit [7:0] queued();
    bit [7:0] q;
    q = pend & chen & ~susp;
    for (int i = 0; i < 8; i++)
      if (!lvlen[lvl[2*i+:2]]) q[i] = 1'b0;
    return q;
  endfunction

  // highest level first, then lowest channel number
  function automatic int pick(bit [7:0] q);
    for (int lv = 3; lv >= 0; lv--)
      for (int i = 0; i < 8; i++)
        if (q[i] && lvl[2*i+:2] == lv) return i;
    return 0;
  endfunction

  // model sees pre-edge values, so it mirrors registered behaviour
  always @(posedge core_clk) begin : mdl
    bit [7:0] q, c, s, mo, w, tr;
    if (rst) begin
      {pend, busy, susp, chen, flag, mask} = '0;
      lvl = '0;
      lvlen = 4'hf;
      {gv, m_irq} = '0;
      st = 0;
    end else begin
      chk(grant.valid, gv, "grant_valid");
      if (gv) begin
        chk(grant.ch, cur, "grant_ch");
        chk(grant.first, gf, "grant_first");
      end
      chk(irq, m_irq, "irq");
      q = queued();
      c = chen;
      s = susp;
      mo = mask;
      w = apb_req.pwdata[7:0];
      tr = chan_trig;
      gv = 1'b0;
      if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1
          && apb_req.pwrite && apb_rsp.pslverr === 1'b0) begin
        case (apb_req.paddr)
          dca_pkg::OFS_CTRL: lvlen = apb_req.pwdata[3:0];
          dca_pkg::OFS_CHEN: begin
            chen = w;
            pend &= w;
          end
          dca_pkg::OFS_SUSP: susp |= w;
          dca_pkg::OFS_RESUME: susp &= ~w;
          dca_pkg::OFS_LVL: lvl = apb_req.pwdata[15:0];
          dca_pkg::OFS_FLAG: flag &= ~w;
          dca_pkg::OFS_MASK: mask = w;
          dca_pkg::OFS_SWTRIG: tr |= w;
          default: ;
        endcase
      end
      if (st == 2 && burst_done.valid) begin
        st = 0;
        if (burst_done.outcome == dca_pkg::DCA_OUT_REQUEUE) begin
          pend[cur] = 1'b1;
        end else begin
          busy[cur] = 1'b0;
          flag[cur] = 1'b1;
        end
        if (burst_done.outcome == dca_pkg::DCA_OUT_SUSPEND) susp[cur] = 1'b1;
        if (burst_done.outcome == dca_pkg::DCA_OUT_DISABLE) chen[cur] = 1'b0;
      end else if (st == 1) begin
        st = 2;
      end else if (st == 0 && q != 0) begin
        cur = pick(q);
        gv = 1'b1;
        gf = !busy[cur];
        pend[cur] = 1'b0;
        busy[cur] = 1'b1;
        st = 1;
      end
      pend |= tr & c & ~s;
      // a disable outcome also drops a trigger that landed while running
      pend &= chen;
      m_irq = |(flag & mo);
    end
  end

  // engine answers at random pace and with random outcomes
  always @(posedge core_clk) begin
    delay <= 4'($urandom_range(5));
    outcome <= dca_pkg::dca_outcome_t'(2'($urandom_range(3)));
  end

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1, "pready_wait");
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    // let the model settle on this edge before expectations are taken
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, 1'b0, "write_err");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(e, 1'b0, "read_err");
    chk(r, x, nm);
  endtask

  // grants may run on; wait until model says nothing queued or running
  task automatic quiet();
    int n;
    n = 0;
    while ((queued() != 0 || st != 0) && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) chk(1'b0, 1'b1, "quiet_wait");
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    int n;
    logic [31:0] d;
    logic e;
    rst = 1'b1;
    chan_trig = '0;
    apb_req = '0;
    n = $urandom(51);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(dca_pkg::OFS_CTRL, 32'h0000000f, "ctrl_rst");
    rd(dca_pkg::OFS_CHEN, 32'h0, "chen_rst");
    rd(dca_pkg::OFS_LVL, 32'h0, "lvl_rst");
    rd(dca_pkg::OFS_BUSY, 32'h0, "busy_rst");
    rd(dca_pkg::OFS_MASK, 32'h0, "mask_rst");
    apb(1'b0, 12'h040, 32'h0, d, e);
    chk(e, 1'b1, "unmapped_err");
    chk(d, 32'h0, "unmapped_data");
    wr(dca_pkg::OFS_PEND, 32'h000000ff);
    rd(dca_pkg::OFS_PEND, 32'h0, "pend_ro");
    wr(dca_pkg::OFS_CHEN, 32'h000000ff);
    for (n = 0; n < 40; n++) begin
      wr(dca_pkg::OFS_LVL, {16'h0, 16'($urandom)});
      wr(dca_pkg::OFS_MASK, {24'h0, 8'($urandom)});
      wr(dca_pkg::OFS_CTRL, {28'h0, 4'($urandom)});
      @(posedge core_clk);
      chan_trig <= 8'($urandom);
      @(posedge core_clk);
      chan_trig <= '0;
      wr(dca_pkg::OFS_SWTRIG, {24'h0, 8'($urandom)});
      quiet();
      wr(dca_pkg::OFS_SUSP, {24'h0, 8'($urandom)});
      rd(dca_pkg::OFS_PEND, {24'h0, pend}, "pend_susp");
      wr(dca_pkg::OFS_CTRL, 32'h0000000f);
      quiet();
      rd(dca_pkg::OFS_PEND, {24'h0, pend}, "pend_held");
      wr(dca_pkg::OFS_CHEN, {24'h0, 8'($urandom)});
      rd(dca_pkg::OFS_PEND, {24'h0, pend}, "pend_dis");
      wr(dca_pkg::OFS_RESUME, 32'h000000ff);
      quiet();
      rd(dca_pkg::OFS_PEND, {24'h0, pend}, "pend_res");
      rd(dca_pkg::OFS_ACTIVE, {29'h0, 3'(cur)}, "active");
      rd(dca_pkg::OFS_BUSY, {24'h0, busy}, "busy");
      rd(dca_pkg::OFS_FLAG, {24'h0, flag}, "flag");
      wr(dca_pkg::OFS_FLAG, 32'h000000ff);
      wr(dca_pkg::OFS_CHEN, 32'h000000ff);
    end
    report_and_stop();
  end

  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
endmodule

// *** tb/dca_engine_model.sv ***
// engine stand-in: answers every grant with a done pulse after a delay
`timescale 1ns/10ps
module dca_engine_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire dca_pkg::dca_grant_t grant,
  input wire logic [3:0] delay,
  input wire dca_pkg::dca_outcome_t outcome,
  output dca_pkg::dca_done_t burst_done
);
  logic [3:0] cnt;
  logic armed;
  // done never precedes run state: earliest in the second cycle after the grant pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      armed <= 1'b0;
      burst_done <= '0;
    end else begin
      burst_done <= '0;
      if (grant.valid) begin
        armed <= 1'b1;
        cnt <= delay;
      end else if (armed && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (armed) begin
        armed <= 1'b0;
        burst_done <= '{1'b1, outcome};
      end
    end
  end
endmodule
